// [rtl/eba_consts.vh]
/*
 * Constants of the eight-bit accumulator arithmetic datapath: operation
 * codes, flag bit positions, register port offsets, reset values and
 * machine-cycle timing counts.
 * Assumes it is included by bare name from the design files, once per file.
 */
`ifndef EBA_CONSTS_VH
`define EBA_CONSTS_VH

// ****************************************************************
// Operation codes
// ****************************************************************
`define EBA_OP_ADC_R      4'h0
`define EBA_OP_SUB_R      4'h1
`define EBA_OP_SUBB_R     4'h2
`define EBA_OP_AND_R      4'h3
`define EBA_OP_DEC_ADJ    4'h4
`define EBA_OP_NEGATE     4'h5
`define EBA_OP_CARRY_INV  4'h6
`define EBA_OP_CARRY_SET  4'h7
`define EBA_OP_ADD_N      4'h8
`define EBA_OP_ADC_N      4'h9
`define EBA_OP_ADD_R      4'ha

// ****************************************************************
// Flag bit positions in the flag register
// ****************************************************************
`define EBA_FLAG_S        7
`define EBA_FLAG_Z        6
`define EBA_FLAG_H        4
`define EBA_FLAG_PV       2
`define EBA_FLAG_N        1
`define EBA_FLAG_C        0

// ****************************************************************
// Register port offsets and reset values
// ****************************************************************
`define EBA_ADDR_ACC      2'h0
`define EBA_ADDR_FLAGS    2'h1
`define EBA_ADDR_STATUS   2'h2
`define EBA_ACC_RESET     8'h00
`define EBA_FLAGS_RESET   8'h00

// ****************************************************************
// Timing in clock states (one state is one SYS_CLK cycle)
// ****************************************************************
`define EBA_MC_STATES     4'h4
`define EBA_IMM_STATES    4'h7
`define EBA_NEGATE_STATES 4'h8

// ****************************************************************
// Decimal adjust correction values
// ****************************************************************
`define EBA_ADJ_LOW       8'h06
`define EBA_ADJ_HIGH      8'h60

`endif

// [rtl/eba_addsub.v]
/*
 * Eight-bit adder/subtractor with carry in, giving the sum together with
 * the half-carry, carry and signed overflow conditions.
 * Assumes its inputs are stable for the cycle; it is purely combinational.
 */
`timescale 1ns/1ps

module eba_addsub (
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       cin,
    input  wire       sub,
    output wire [7:0] sum,
    output wire       half,
    output wire       carry,
    output wire       ovf
);

    // ****************************************************************
    // Subtraction as addition of the inverted operand
    // ****************************************************************
    wire [7:0] b_x;
    wire       c_x;
    wire [4:0] low_sum;
    wire [8:0] full_sum;

    // Borrow in becomes inverted carry in when subtracting
    assign b_x      = sub ? ~b : b;
    assign c_x      = sub ? ~cin : cin;
    assign low_sum  = {1'b0, a[3:0]} + {1'b0, b_x[3:0]} + {4'h0, c_x};
    assign full_sum = {1'b0, a} + {1'b0, b_x} + {8'h00, c_x};

    // Results; a missing carry out means a borrow
    assign sum   = full_sum[7:0];
    assign half  = sub ? ~low_sum[4] : low_sum[4];
    assign carry = sub ? ~full_sum[8] : full_sum[8];
    assign ovf   = (a[7] == b_x[7]) && (full_sum[7] != a[7]);

endmodule

// [rtl/eba_alu.v]
/*
 * Accumulator arithmetic and logic datapath: holds the accumulator and
 * the flag register, runs one operation at a time for its documented
 * number of clock states, and commits result and flags at the end.
 * Assumes the instruction decoder drives OP_START, OP_CODE and OPERAND
 * from logic on SYS_CLK, and supplies the immediate byte on OPERAND in
 * the last state of the first machine cycle.
 */
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "eba_consts.vh"

module eba_alu (
    input  wire       SYS_CLK,
    input  wire       RST,
    input  wire       OP_START,
    input  wire [3:0] OP_CODE,
    input  wire [7:0] OPERAND,
    input  wire [1:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    output reg  [7:0] ACC,
    output reg  [7:0] FLAGS,
    output reg        BUSY,
    output reg        OP_DONE
);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************

    // Number of clock states an operation occupies
    function [3:0] op_states;
        input [3:0] op;
        begin
            case (op)
                `EBA_OP_NEGATE: op_states = `EBA_NEGATE_STATES;
                `EBA_OP_ADD_N: op_states = `EBA_IMM_STATES;
                `EBA_OP_ADC_N: op_states = `EBA_IMM_STATES;
                default:       op_states = `EBA_MC_STATES;
            endcase
        end
    endfunction

    // Immediate forms take their operand in the last state of the first machine cycle
    function is_imm;
        input [3:0] op;
        begin
            is_imm = (op == `EBA_OP_ADD_N) || (op == `EBA_OP_ADC_N);
        end
    endfunction

    // Legal operation codes
    function is_legal;
        input [3:0] op;
        begin
            is_legal = (op <= `EBA_OP_ADD_R);
        end
    endfunction

    // Even parity of a byte gives a one
    function parity_even;
        input [7:0] v;
        integer i;
        reg     p;
        begin
            p = 1'b1;
            for (i = 0; i < 8; i = i + 1) begin
                p = p ^ v[i];
            end
            parity_even = p;
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg       state;
    reg [3:0] op_q;
    reg [7:0] opnd_q;
    reg [3:0] cnt;
    reg [3:0] last_cnt;

    // Next values of the sequencer
    reg       next_state;
    reg [3:0] next_cnt;

    // Result of the running operation
    reg [7:0] next_acc;
    reg [7:0] next_flags;

    // Adder hookup
    reg  [7:0] add_a;
    reg  [7:0] add_b;
    reg        add_cin;
    reg        add_sub;
    wire [7:0] add_sum;
    wire       add_half;
    wire       add_carry;
    wire       add_ovf;

    // Decimal adjust intermediates
    reg        adj_lo_fix;
    reg        adj_hi_fix;
    reg  [7:0] adj_corr;
    reg  [7:0] adj_res;

    // Current flag bits, start acceptance and commit condition for readability
    wire cur_c;
    wire cur_h;
    wire cur_n;
    wire start_ok;
    wire commit;

    assign cur_c    = FLAGS[`EBA_FLAG_C];
    assign cur_h    = FLAGS[`EBA_FLAG_H];
    assign cur_n    = FLAGS[`EBA_FLAG_N];
    assign start_ok = (state == ST_IDLE) && OP_START && is_legal(OP_CODE);
    assign commit   = (state == ST_RUN) && (cnt == last_cnt);

    // ****************************************************************
    // Shared adder/subtractor
    // ****************************************************************
    eba_addsub u_addsub (
        .a     (add_a),
        .b     (add_b),
        .cin   (add_cin),
        .sub   (add_sub),
        .sum   (add_sum),
        .half  (add_half),
        .carry (add_carry),
        .ovf   (add_ovf)
    );

    // Operand steering for each operation
    always @* begin
        add_a   = ACC;
        add_b   = opnd_q;
        add_cin = 1'b0;
        add_sub = 1'b0;
        case (op_q)
            `EBA_OP_ADC_R: add_cin = cur_c;
            `EBA_OP_ADC_N: add_cin = cur_c;
            `EBA_OP_SUB_R: add_sub = 1'b1;
            `EBA_OP_SUBB_R: begin
                add_sub = 1'b1;
                add_cin = cur_c;
            end
            `EBA_OP_NEGATE: begin
                add_a   = 8'h00;
                add_b   = ACC;
                add_sub = 1'b1;
            end
            `EBA_OP_DEC_ADJ: begin
                add_b   = adj_corr;
                add_sub = cur_n;
            end
            default: begin
                add_cin = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Decimal adjust correction
    // ****************************************************************

    // Correction chosen from prior C, H, N and the two digits
    always @* begin
        adj_lo_fix = cur_h || (ACC[3:0] > 4'h9);
        adj_hi_fix = cur_c || (ACC > 8'h99);
        if (cur_n) begin
            adj_lo_fix = cur_h;
            adj_hi_fix = cur_c;
        end
        adj_corr = (adj_lo_fix ? `EBA_ADJ_LOW : 8'h00)
                 | (adj_hi_fix ? `EBA_ADJ_HIGH : 8'h00);
    end

    // Adjusted byte comes back from the shared adder; kept apart so
    // the correction and the sum never sit in one looping process
    always @* begin
        adj_res = add_sum;
    end

    // ****************************************************************
    // Result and flag computation
    // ****************************************************************

    // Flags not named by an operation keep their value
    always @* begin
        next_acc   = ACC;
        next_flags = FLAGS;
        case (op_q)
            `EBA_OP_ADC_R, `EBA_OP_ADC_N, `EBA_OP_ADD_N, `EBA_OP_ADD_R,
            `EBA_OP_SUB_R, `EBA_OP_SUBB_R, `EBA_OP_NEGATE: begin
                next_acc                = add_sum;
                next_flags[`EBA_FLAG_S]  = add_sum[7];
                next_flags[`EBA_FLAG_Z]  = (add_sum == 8'h00);
                next_flags[`EBA_FLAG_H]  = add_half;
                next_flags[`EBA_FLAG_PV] = add_ovf;
                next_flags[`EBA_FLAG_N]  = add_sub;
                next_flags[`EBA_FLAG_C]  = add_carry;
            end
            `EBA_OP_AND_R: begin
                next_acc                = ACC & opnd_q;
                next_flags[`EBA_FLAG_S]  = next_acc[7];
                next_flags[`EBA_FLAG_Z]  = (next_acc == 8'h00);
                next_flags[`EBA_FLAG_H]  = 1'b1;
                next_flags[`EBA_FLAG_PV] = parity_even(next_acc);
                next_flags[`EBA_FLAG_N]  = 1'b0;
                next_flags[`EBA_FLAG_C]  = 1'b0;
            end
            `EBA_OP_DEC_ADJ: begin
                next_acc                = adj_res;
                next_flags[`EBA_FLAG_S]  = adj_res[7];
                next_flags[`EBA_FLAG_Z]  = (adj_res == 8'h00);
                next_flags[`EBA_FLAG_PV] = parity_even(adj_res);
                next_flags[`EBA_FLAG_C]  = adj_hi_fix;
                if (cur_n) begin
                    next_flags[`EBA_FLAG_H] = cur_h && (ACC[3:0] < 4'h6);
                end else begin
                    next_flags[`EBA_FLAG_H] = (ACC[3:0] > 4'h9);
                end
            end
            `EBA_OP_CARRY_INV: begin
                next_flags[`EBA_FLAG_H] = cur_c;
                next_flags[`EBA_FLAG_C] = ~cur_c;
                next_flags[`EBA_FLAG_N] = 1'b0;
            end
            `EBA_OP_CARRY_SET: begin
                next_flags[`EBA_FLAG_C] = 1'b1;
                next_flags[`EBA_FLAG_H] = 1'b0;
                next_flags[`EBA_FLAG_N] = 1'b0;
            end
            default: begin
                next_acc = ACC;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // State counting through the clock states of one operation
    always @* begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_IDLE: begin
                if (start_ok) begin
                    next_state = ST_RUN;
                    next_cnt   = 4'h0;
                end
            end
            ST_RUN: begin
                if (commit) begin
                    next_state = ST_IDLE;
                    next_cnt   = 4'h0;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = 4'h0;
            end
        endcase
    end

    // Sequencer registers and operand capture
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            op_q     <= `EBA_OP_ADC_R;
            opnd_q   <= 8'h00;
            last_cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (start_ok) begin
                op_q     <= OP_CODE;
                opnd_q   <= OPERAND;
                last_cnt <= op_states(OP_CODE) - 4'h1;
            end else if (state == ST_RUN && is_imm(op_q)
                         && cnt == `EBA_MC_STATES - 4'h1) begin
                opnd_q <= OPERAND;
            end
        end
    end

    // ****************************************************************
    // Accumulator, flags and status outputs
    // ****************************************************************

    // Commit at the last state; software writes only while idle
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ACC     <= `EBA_ACC_RESET;
            FLAGS   <= `EBA_FLAGS_RESET;
            BUSY    <= 1'b0;
            OP_DONE <= 1'b0;
        end else begin
            BUSY    <= (next_state == ST_RUN);
            OP_DONE <= commit;
            if (commit) begin
                ACC   <= next_acc;
                FLAGS <= next_flags;
            end else if (state == ST_IDLE && !start_ok && REG_WR) begin
                if (REG_ADDR == `EBA_ADDR_ACC) begin
                    ACC <= REG_WDATA;
                end
                if (REG_ADDR == `EBA_ADDR_FLAGS) begin
                    FLAGS <= REG_WDATA;
                end
            end
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************

    // Read data stand for exactly the cycle after the strobe
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `EBA_ADDR_ACC:    REG_RDATA <= ACC;
                `EBA_ADDR_FLAGS:  REG_RDATA <= FLAGS;
                `EBA_ADDR_STATUS: REG_RDATA <= {4'h0, op_q[2:0] & 3'h0, BUSY};
                default:          REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule

// [dv/eba_alu_properties.sv]
/* Checker of the accumulator datapath: run length and flag relations.
 * Assumes it is bound to eba_alu and sees only that module's ports. */
`timescale 1ns/1ps

module eba_alu_properties (
    input wire       SYS_CLK,
    input wire       RST,
    input wire       OP_START,
    input wire [3:0] OP_CODE,
    input wire [7:0] OPERAND,
    input wire [1:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire [7:0] REG_RDATA,
    input wire [7:0] ACC,
    input wire [7:0] FLAGS,
    input wire       BUSY,
    input wire       OP_DONE
);
    // ********
    // Tracking
    // ********
    reg  [3:0] last_code;
    wire       take = OP_START && !BUSY && (OP_CODE <= 4'ha);
    wire       imm  = (OP_CODE == 4'h8) || (OP_CODE == 4'h9);
    wire       negate = (OP_CODE == 4'h5);

    // Code of the operation in flight
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            last_code <= 4'hf;
        end else if (take) begin
            last_code <= OP_CODE;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    // Busy for the state count, then one commit with busy low
    sequence run4_s;
        BUSY [*4] ##1 (OP_DONE && !BUSY);
    endsequence
    sequence run7_s;
        BUSY [*7] ##1 (OP_DONE && !BUSY);
    endsequence
    sequence run8_s;
        BUSY [*8] ##1 (OP_DONE && !BUSY);
    endsequence

    // ********
    // Checks
    // ********
    short_run_a: assert property (take && !imm && !negate |=> run4_s)
        else $error("short operation length wrong");
    imm_run_a: assert property (take && imm |=> run7_s)
        else $error("immediate operation length wrong");
    negate_run_a: assert property (take && negate |=> run8_s)
        else $error("negate length wrong");
    done_pulse_a: assert property (OP_DONE |=> !OP_DONE)
        else $error("done longer than one cycle");
    acc_cause_a: assert property ($changed(ACC)
        |-> OP_DONE || $past(REG_WR && REG_ADDR == 2'h0))
        else $error("accumulator changed without cause");
    sign_zero_a: assert property (OP_DONE && last_code != 4'h6
        && last_code != 4'h7 |-> FLAGS[7] == ACC[7] && FLAGS[6] == (ACC == 8'h00))
        else $error("sign or zero wrong");
    and_flags_a: assert property (OP_DONE && last_code == 4'h3
        |-> FLAGS[4] && !FLAGS[1] && !FLAGS[0] && FLAGS[2] == ~^ACC)
        else $error("logical flags wrong");
    carry_flip_a: assert property (OP_DONE && last_code == 4'h6
        |-> FLAGS[0] != $past(FLAGS[0]) && FLAGS[4] == $past(FLAGS[0]) && !FLAGS[1]
        && FLAGS[7:6] == $past(FLAGS[7:6]) && FLAGS[2] == $past(FLAGS[2]))
        else $error("carry complement flags wrong");
    carry_force_a: assert property (OP_DONE && last_code == 4'h7
        |-> FLAGS[0] && !FLAGS[4] && !FLAGS[1] && FLAGS[7:6] == $past(FLAGS[7:6])
        && FLAGS[2] == $past(FLAGS[2]))
        else $error("carry force flags wrong");
    sub_mark_a: assert property (OP_DONE
        && (last_code inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha})
        |-> FLAGS[1] == (last_code inside {4'h1, 4'h2, 4'h5}))
        else $error("subtract flag wrong");
endmodule

bind eba_alu eba_alu_properties chk (.SYS_CLK(SYS_CLK), .RST(RST), .OP_START(OP_START),
    .OP_CODE(OP_CODE), .OPERAND(OPERAND), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC(ACC), .FLAGS(FLAGS),
    .BUSY(BUSY), .OP_DONE(OP_DONE));

// [dv/eba_decoder_model.sv]
/* Decoder side model: starts operations and supplies operand bytes.
 * Assumes one caller at a time and a free-running clock. */
`timescale 1ns/1ps
`include "eba_consts.vh"

module eba_decoder_model (
    input  wire       clk,
    input  wire       op_done,
    output reg        op_start,
    output reg  [3:0] op_code,
    output reg  [7:0] operand
);
    // ********
    // Driver
    // ********
    // Idle levels at time zero
    initial begin
        op_start = 1'b0;
        op_code  = 4'h0;
        operand  = 8'h00;
    end

    // Start one operation, count states until it commits
    task issue(input [3:0] code, input [7:0] r, input [7:0] n, output integer cyc);
        begin
            cyc = 0;
            @(posedge clk);
            op_start <= 1'b1;
            op_code  <= code;
            operand  <= r;
            @(posedge clk);
            op_start <= 1'b0;
            op_code  <= ~code;
            operand  <= ~r;  // Released byte no longer valid
            if (code == `EBA_OP_ADD_N || code == `EBA_OP_ADC_N) begin
                repeat (3) @(posedge clk);
                operand <= n;  // Immediate byte in the last state of the first machine cycle
                @(posedge clk);
                operand <= ~n;
                cyc = 4;
            end
            while (cyc < 20 && op_done !== 1'b1) begin
                @(posedge clk);
                cyc = cyc + 1;
                #1;
            end
        end
    endtask
endmodule

// [dv/eight_bit_arithmetic_alu_bench.sv]
/* Self-checking bench of the accumulator datapath against a reference model.
 * Assumes the decoder model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "eba_consts.vh"

module eight_bit_arithmetic_alu_bench;
    reg          sys_clk;
    reg          rst;
    reg  [1:0]   reg_addr;
    reg  [7:0]   reg_wdata;
    reg          reg_wr;
    reg          reg_rd;
    wire [7:0]   reg_rdata;
    wire [7:0]   acc;
    wire [7:0]   flags;
    wire         busy;
    wire         op_done;
    wire         op_start;
    wire [3:0]   op_code;
    wire [7:0]   operand;
    integer      miscompares;
    integer      samples_checked;
    integer      seed;
    integer      i;
    integer      cyc;
    reg  [3:0]   op;
    reg  [7:0]   a, f, r, n, d;
    reg  [15:0]  e;

    eba_alu dut (.SYS_CLK(sys_clk), .RST(rst), .OP_START(op_start), .OP_CODE(op_code),
        .OPERAND(operand), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACC(acc), .FLAGS(flags), .BUSY(busy),
        .OP_DONE(op_done));
    eba_decoder_model dec (.clk(sys_clk), .op_done(op_done), .op_start(op_start),
        .op_code(op_code), .operand(operand));

    // ********
    // Helpers
    // ********
    // Reference result: accumulator in the high byte, flags in the low byte
    function [15:0] model(input [3:0] o, input [7:0] x, input [7:0] g, input [7:0] y);
        reg [7:0] k, b, res, cor;
        reg [8:0] s;
        reg [4:0] hs;
        reg       ci, sb, h, c, v, nf;
        reg [1:0] sz;
        begin
            k = (o == `EBA_OP_NEGATE) ? 8'h00 : x;
            b = (o == `EBA_OP_NEGATE) ? x : y;
            ci = (o == 4'h0 || o == 4'h2 || o == 4'h9) ? g[0] : 1'b0;
            sb = (o == 4'h1 || o == 4'h2 || o == 4'h5);
            s = sb ? {1'b0, k} - {1'b0, b} - ci : {1'b0, k} + {1'b0, b} + ci;
            hs = sb ? {1'b0, k[3:0]} - b[3:0] - ci : {1'b0, k[3:0]} + b[3:0] + ci;
            res = s[7:0];
            h = hs[4];
            c = s[8];
            nf = sb;
            v = (sb ^ ~(k[7] ^ b[7])) & (res[7] ^ k[7]);
            case (o)
                4'h3: begin
                    res = x & y;
                    {h, c, nf, v} = {1'b1, 1'b0, 1'b0, ~^(x & y)};
                end
                4'h4: begin
                    cor = 8'h00;
                    c = g[0];
                    if (g[4] || (!g[1] && x[3:0] > 4'h9)) cor = 8'h06;
                    if (g[0] || (!g[1] && x > 8'h99)) begin
                        cor = cor + 8'h60;
                        c = 1'b1;
                    end
                    res = g[1] ? x - cor : x + cor;
                    h = g[1] ? (g[4] && x[3:0] < 4'h6) : (x[3:0] > 4'h9);
                    {nf, v} = {g[1], ~^res};
                end
                4'h6: {res, h, c, nf, v} = {x, g[0], ~g[0], 1'b0, g[2]};
                4'h7: {res, h, c, nf, v} = {x, 1'b0, 1'b1, 1'b0, g[2]};
                default: ;
            endcase
            sz = (o == 4'h6 || o == 4'h7) ? g[7:6] : {res[7], res == 8'h00};
            model = {res, sz, g[5], h, g[3], v, nf, c};
        end
    endfunction

    // Compare one value and count it
    task check(input string name, input logic [7:0] got, input logic [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // Register write, one strobe cycle
    task wr(input [1:0] ad, input [7:0] wd);
        begin
            @(posedge sys_clk);
            reg_wr    <= 1'b1;
            reg_addr  <= ad;
            reg_wdata <= wd;
            @(posedge sys_clk);
            reg_wr    <= 1'b0;
        end
    endtask

    // Register read, data taken in the following cycle
    task rd(input [1:0] ad, output [7:0] rdv);
        begin
            @(posedge sys_clk);
            reg_rd   <= 1'b1;
            reg_addr <= ad;
            @(posedge sys_clk);
            reg_rd   <= 1'b0;
            #1;
            rdv = reg_rdata;
        end
    endtask

    // Verdict and end of run
    task results;
        begin
            $display("checked %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    // ********
    // Stimulus
    // ********
    // Clock, 25 ns period
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge sys_clk);
        miscompares = miscompares + 1;
        results;
    end

    // Main sequence
    initial begin
        {miscompares, samples_checked, seed} = {32'h0, 32'h0, 32'ha1af1394};
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 1'b0, 1'b0, 2'h0, 8'h00};
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(2'h0, d);
        check("acc reset", d, `EBA_ACC_RESET);
        rd(2'h1, d);
        check("flags reset", d, `EBA_FLAGS_RESET);
        rd(2'h3, d);
        check("unmapped", d, 8'h00);
        for (i = 0; i < 66; i = i + 1) begin
            op = i % 11;
            {a, f, r, n} = $random(seed);
            if (i == 5) a = 8'h80;
            if (i == 16) a = 8'h00;
            wr(2'h0, a);
            wr(2'h1, f);
            rd(2'h1, d);
            check("flags write", d, f);
            e = model(op, a, f, (op == 4'h8 || op == 4'h9) ? n : r);
            dec.issue(op, r, n, cyc);
            check("states", cyc[7:0], op == 4'h5 ? 8'h08 : (op == 4'h8 || op == 4'h9) ? 8'h07 : 8'h04);
            check("acc", acc, e[15:8]);
            check("flags", flags, e[7:0]);
        end
        dec.issue(4'hc, r, n, cyc);
        check("illegal states", cyc[7:0], 8'h14);
        check("illegal acc", acc, e[15:8]);
        wr(2'h2, 8'hff);
        rd(2'h2, d);
        check("status", d, 8'h00);
        results;
    end
endmodule
